// ---- core/tmr_params.svh ----
// constants for the eight-bit timer/counter: offsets, fields, resets, timing
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ==========================================================
// register byte offsets
`define TMR_ADR_COUNT   4'h0
`define TMR_ADR_OPTION  4'h4
`define TMR_ADR_INTCTL  4'h8

// ==========================================================
// field positions
`define OPT_SRC         5
`define OPT_EDGE        4
`define OPT_ASSIGN      3
`define OPT_RATE_HI     2
`define INT_FLAG        2
`define INT_EN          5

// ==========================================================
// reset values
`define CNT_RESET       8'h00
`define OPT_RESET       6'h3F
`define PRESC_RESET     8'h00

// ==========================================================
// timing
`define INHIBIT_CYCLES  2'h2
`define PHASE_LAST      2'h3
`define PHASE_TWO_CODE  2'h1

`endif

// ---- core/tmr_pkg.sv ----
// types shared by the timer/counter modules
package tmr_pkg;

	// ==========================================================
	// types
	typedef logic [7:0] byte_t;
	typedef logic [2:0] rate_t;
	typedef enum {SRC_TIMER, SRC_COUNTER} src_e;

endpackage : tmr_pkg

// ---- core/presc_if.sv ----
// link between the timer control and the shared prescaler engine
`timescale 1ns/10ps
interface presc_if;
	import tmr_pkg::*;

	logic  tick;
	logic  clear;
	rate_t rate;
	logic  pulse;

	modport owner  (output tick, output clear, output rate, input pulse);
	modport engine (input tick, input clear, input rate, output pulse);
endinterface : presc_if

// ---- core/phase_gen.sv ----
// four-phase divider giving phase_two and phase_four enables
`timescale 1ns/10ps
`include "tmr_params.svh"
module phase_gen (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// phase enables
	output logic      phase_two_o,
	output logic      phase_four_o
);

	logic [1:0] phase;

	// ==========================================================
	// phase counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign phase_two_o  = (phase == `PHASE_TWO_CODE);
	assign phase_four_o = (phase == `PHASE_LAST);

	a_phase_space: assert property (@(posedge clk_i) disable iff (rst_i)
		phase_four_o |=> !phase_four_o [*3] ##1 phase_four_o)
		else $error("phase_four spacing wrong");

endmodule : phase_gen

// ---- core/presc_core.sv ----
// shared eight-bit prescaler counter with power-of-two tap select
`timescale 1ns/10ps
`include "tmr_params.svh"
module presc_core
	import tmr_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control and output
	presc_if.engine   p
);

	logic [WIDTH-1:0] cnt;
	logic [WIDTH-1:0] mask;

	// ==========================================================
	// tap mask: bits 0..rate set, so division is 2**(rate+1)
	for (genvar i = 0; i < WIDTH; i++) begin : g_mask
		assign mask[i] = (i <= int'(p.rate));
	end

	// ==========================================================
	// counter, not visible to software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= WIDTH'(`PRESC_RESET);
		end else if (p.clear) begin
			cnt <= WIDTH'(`PRESC_RESET);
		end else if (p.tick) begin
			cnt <= cnt + WIDTH'(1);
		end
	end

	assign p.pulse = p.tick & !p.clear & ((cnt & mask) == mask);

	a_presc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		p.clear |=> cnt == `PRESC_RESET)
		else $error("prescaler not cleared");
	a_presc_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
		p.pulse && p.rate == 3'h0 |-> cnt[0] && !$past(p.pulse))
		else $error("divide by two broken");

endmodule : presc_core

// ---- core/tmr_counter8.sv ----
// eight-bit timer/counter with shared prescaler and wishbone registers
//
// Functional notes
// - timer mode, no prescaler: count advances once per instruction cycle
// - writing the count blocks counting for the next two instruction cycles
// - counter mode counts selected external edges, rising or falling
// - source select one picks counter mode, zero picks timer mode
// - one prescaler, either timer or watchdog; assign bit zero gives timer
// - timer prescaler offers eight ratios 1:2 to 1:256 by rate field
// - assign bit set hands prescaler to watchdog; timer counts 1:1
// - prescaler hidden; count write clears it while assigned to timer
// - wrap from FFh to 00h sets overflow flag, enabled or not
// - overflow flag stays set until software clears it
// - interrupt enable bit gates the flag onto the interrupt request
// - counter mode samples prescaler output on phases two and four
// - in sleep counting stops and count holds its value
`timescale 1ns/10ps
`include "tmr_params.svh"
module tmr_counter8
	import tmr_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// device state and count pin
	input  wire logic        sleep_i,
	input  wire logic        ext_count_input_i,
	// watchdog side of the shared prescaler
	input  wire logic        wdt_tick_i,
	input  wire logic        wdt_clear_i,
	output logic             wdt_scaled_o,
	// interrupt
	output logic             irq_o
);

	byte_t      timer_count_value;
	logic [5:0] option_config;
	logic       overflow_flag;
	logic       overflow_irq_enable;
	logic [1:0] inhibit;
	logic       ext_prev;
	logic       sync_pend;
	logic       phase_two;
	logic       phase_four;
	src_e       src;
	logic       prescaler_assign;
	logic       ext_edge;
	logic       raw_event;
	logic       scaled;
	logic       advance;
	logic       inc;
	logic       next_flag;
	logic       next_en;
	logic       req;
	logic       take;
	logic       wr;
	logic       wr_cnt;
	logic       wr_opt;
	logic       wr_int;

	presc_if pi ();

	phase_gen u_phase (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.phase_two_o  (phase_two),
		.phase_four_o (phase_four)
	);

	presc_core #(.WIDTH(8)) u_presc (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.p     (pi)
	);

	// ==========================================================
	// bus decode: ack one cycle after request, write at the ack edge
	assign req    = cyc_i & stb_i;
	assign take   = req & !ack_o;
	assign wr     = req & ack_o & we_i & sel_i[0];
	assign wr_cnt = wr & (adr_i == `TMR_ADR_COUNT);
	assign wr_opt = wr & (adr_i == `TMR_ADR_OPTION);
	assign wr_int = wr & (adr_i == `TMR_ADR_INTCTL);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= take;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (take) begin
			unique case (adr_i)
				`TMR_ADR_COUNT:  dat_o <= {24'h0, timer_count_value};
				`TMR_ADR_OPTION: dat_o <= {26'h0, option_config};
				`TMR_ADR_INTCTL: dat_o <= {26'h0, overflow_irq_enable,
					2'h0, overflow_flag, 2'h0};
				default:         dat_o <= 32'h0;
			endcase
		end
	end

	// ==========================================================
	// source and prescaler routing
	always_comb begin
		src = option_config[`OPT_SRC] ? SRC_COUNTER : SRC_TIMER;
	end
	assign prescaler_assign = option_config[`OPT_ASSIGN];

	// edge select one counts falling edges
	assign ext_edge = option_config[`OPT_EDGE] ?
		(ext_prev & !ext_count_input_i) :
		(!ext_prev & ext_count_input_i);
	assign raw_event = (src == SRC_COUNTER) ? ext_edge : phase_four;

	// watchdog keeps its prescaler in sleep; the timer path freezes
	assign pi.tick  = prescaler_assign ? wdt_tick_i :
		(raw_event & !sleep_i);
	assign pi.clear = prescaler_assign ? wdt_clear_i : wr_cnt;
	assign pi.rate  = option_config[`OPT_RATE_HI:0];
	assign scaled   = prescaler_assign ? (raw_event & !sleep_i) :
		pi.pulse;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= ext_count_input_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_scaled_o <= 1'b0;
		end else begin
			wdt_scaled_o <= prescaler_assign & pi.pulse;
		end
	end

	// ==========================================================
	// counter-mode synchroniser: set wins over consumption
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_pend <= 1'b0;
		end else if (scaled && src == SRC_COUNTER) begin
			sync_pend <= 1'b1;
		end else if (phase_two || phase_four) begin
			sync_pend <= 1'b0;
		end
	end

	assign advance = (src == SRC_COUNTER) ?
		(sync_pend & (phase_two | phase_four)) : scaled;
	assign inc = advance & !sleep_i & (inhibit == 2'h0) & !wr_cnt;

	// ==========================================================
	// write inhibit: counts down on instruction-cycle boundaries
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inhibit <= 2'h0;
		end else if (wr_cnt) begin
			inhibit <= `INHIBIT_CYCLES;
		end else if (phase_four && inhibit != 2'h0) begin
			inhibit <= inhibit - 2'h1;
		end
	end

	// ==========================================================
	// count and configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_count_value <= `CNT_RESET;
		end else if (wr_cnt) begin
			timer_count_value <= dat_i[7:0];
		end else if (inc) begin
			timer_count_value <= timer_count_value + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			option_config <= `OPT_RESET;
		end else if (wr_opt) begin
			option_config <= dat_i[5:0];
		end
	end

	// ==========================================================
	// overflow flag and interrupt; a new overflow beats a clear
	assign next_flag = (inc && timer_count_value == 8'hFF) ||
		(overflow_flag && !(wr_int && dat_i[`INT_FLAG]));
	assign next_en = wr_int ? dat_i[`INT_EN] : overflow_irq_enable;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag       <= 1'b0;
			overflow_irq_enable <= 1'b0;
		end else begin
			overflow_flag       <= next_flag;
			overflow_irq_enable <= next_en;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_flag & next_en;
		end
	end

	// ==========================================================
	// checks
	sequence s_count_write;
		wr_cnt;
	endsequence

	sequence s_blocked;
		!inc [*4];
	endsequence

	property p_write_blocks;
		@(posedge clk_i) disable iff (rst_i)
		s_count_write |=> s_blocked;
	endproperty

	a_write_blocks: assert property (p_write_blocks)
		else $error("count advanced right after a write");
	a_timer_step: assert property (@(posedge clk_i) disable iff (rst_i)
		src == SRC_TIMER && prescaler_assign && phase_four && !sleep_i &&
		inhibit == 2'h0 && !wr_cnt
		|=> timer_count_value == $past(timer_count_value) + 8'h01)
		else $error("timer mode did not step");
	a_edge_pend: assert property (@(posedge clk_i) disable iff (rst_i)
		src == SRC_COUNTER && prescaler_assign && ext_edge && !sleep_i
		|=> sync_pend)
		else $error("external edge lost");
	a_sync_phase: assert property (@(posedge clk_i) disable iff (rst_i)
		inc && src == SRC_COUNTER |-> phase_two || phase_four)
		else $error("counter advanced off phase");
	a_wdt_route: assert property (@(posedge clk_i) disable iff (rst_i)
		prescaler_assign |-> pi.tick == wdt_tick_i)
		else $error("prescaler not given to watchdog");
	a_ovf_set: assert property (@(posedge clk_i) disable iff (rst_i)
		inc && timer_count_value == 8'hFF
		|=> overflow_flag && timer_count_value == 8'h00)
		else $error("overflow not flagged");
	a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow_flag && !(wr_int && dat_i[`INT_FLAG])
		|=> overflow_flag)
		else $error("overflow flag dropped");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == (overflow_flag && overflow_irq_enable))
		else $error("interrupt not gated by enable");
	a_sleep_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		sleep_i && !wr_cnt |=> $stable(timer_count_value))
		else $error("count moved in sleep");
	a_reset_clear: assert property (@(posedge clk_i)
		rst_i |=> timer_count_value == `CNT_RESET)
		else $error("count not cleared by reset");

endmodule : tmr_counter8

// ---- bench/tb_top.sv ----
// self-checking bench for the eight-bit timer/counter
`timescale 1ns/10ps
`include "tmr_params.svh"
module tb_top;
	import tmr_pkg::*;

	// ==================
	// signals
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [3:0]  adr_i = 4'h0;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        sleep_i = 1'b0;
	logic        pin = 1'b0;
	logic        tick = 1'b0;
	logic        wclr = 1'b0;
	logic        wdt_scaled_o;
	logic        irq_o;
	int          errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          scaled = 0;
	int          n;
	byte_t       a;
	byte_t       b;

	tmr_counter8 uut (
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .sleep_i,
		.ext_count_input_i(pin), .wdt_tick_i(tick),
		.wdt_clear_i(wclr), .wdt_scaled_o, .irq_o
	);

	always #25 clk_i = ~clk_i;

	// cycle ceiling: the whole sequence needs well under half of it
	always @(posedge clk_i) begin
		cycles++;
		if (wdt_scaled_o === 1'b1)
			scaled++;
		if (cycles == 30000) begin
			errors++;
			end_sim();
		end
	end

	// ==================
	// tasks
	task automatic end_sim();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	task automatic chk(input byte_t got, input byte_t exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// classic cycle: request held until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] ad,
			input byte_t d, output byte_t q);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		dat_i <= {24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'b1) @(posedge clk_i);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [3:0] ad, input byte_t d);
		byte_t q;
		wb(1'b1, ad, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] ad, output byte_t q);
		wb(1'b0, ad, 8'h00, q);
	endtask : rd

	// two count reads whose sampling edges lie g+3 clocks apart
	task automatic span(input int g, input byte_t e);
		rd(`TMR_ADR_COUNT, a);
		repeat (g) @(posedge clk_i);
		rd(`TMR_ADR_COUNT, b);
		chk(b - a, e);
	endtask : span

	task automatic pulses(input int k);
		repeat (k) begin
			pin <= 1'b1;
			repeat (8) @(posedge clk_i);
			pin <= 1'b0;
			repeat (8) @(posedge clk_i);
		end
	endtask : pulses

	task automatic irq_chk(input logic e);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq_o}, {7'h0, e});
	endtask : irq_chk

	function automatic int div_of(input logic asg, input rate_t r);
		return asg ? 1 : 2 << r;
	endfunction : div_of

	// ==================
	// sequence
	initial begin
		void'($urandom(32'hD19F1553));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`TMR_ADR_COUNT, a);
		chk(a, `CNT_RESET);
		rd(`TMR_ADR_OPTION, a);
		chk(a, {2'b00, `OPT_RESET});
		rd(`TMR_ADR_INTCTL, a);
		chk(a, 8'h00);
		wr(4'hC, 8'hFF);
		rd(4'hC, a);
		chk(a, 8'h00);
		sel_i <= 4'h0;
		wr(`TMR_ADR_OPTION, 8'h00);
		sel_i <= 4'hF;
		rd(`TMR_ADR_OPTION, a);
		chk(a, {2'b00, `OPT_RESET});
		// clear watchdog and prescaler before handing it back to the timer
		wclr <= 1'b1;
		@(posedge clk_i);
		wclr <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			wr(`TMR_ADR_OPTION, byte_t'(i));
			n = $urandom_range(3, 1);
			span(4 * div_of(i[3], i[2:0]) * n - 3, byte_t'(n));
		end
		wr(`TMR_ADR_OPTION, 8'h08);
		n = $urandom_range(255, 0);
		wr(`TMR_ADR_COUNT, byte_t'(n));
		rd(`TMR_ADR_COUNT, a);
		chk(a, byte_t'(n));
		repeat (37) @(posedge clk_i);
		rd(`TMR_ADR_COUNT, b);
		chk((b - a) | 8'h01, 8'h09);
		sleep_i <= 1'b1;
		span(37, 8'h00);
		sleep_i <= 1'b0;
		// a stale prescaler would advance the count long before 1024 clocks
		wr(`TMR_ADR_OPTION, 8'h07);
		repeat (600) @(posedge clk_i);
		wr(`TMR_ADR_COUNT, 8'h10);
		repeat (995) @(posedge clk_i);
		rd(`TMR_ADR_COUNT, a);
		chk(a, 8'h10);
		repeat (45) @(posedge clk_i);
		rd(`TMR_ADR_COUNT, a);
		chk(a, 8'h11);
		wr(`TMR_ADR_OPTION, 8'h08);
		wr(`TMR_ADR_INTCTL, 8'h04);
		wr(`TMR_ADR_COUNT, 8'hFE);
		repeat (30) @(posedge clk_i);
		rd(`TMR_ADR_INTCTL, a);
		chk(a, 8'h04);
		irq_chk(1'b0);
		wr(`TMR_ADR_INTCTL, 8'h20);
		irq_chk(1'b1);
		rd(`TMR_ADR_INTCTL, a);
		chk(a, 8'h24);
		wr(`TMR_ADR_INTCTL, 8'h24);
		irq_chk(1'b0);
		rd(`TMR_ADR_INTCTL, a);
		chk(a, 8'h20);
		for (int e = 0; e < 2; e++) begin
			wr(`TMR_ADR_OPTION, e ? 8'h38 : 8'h28);
			n = $urandom_range(6, 1);
			rd(`TMR_ADR_COUNT, a);
			pulses(n);
			pin <= 1'b1;
			repeat (16) @(posedge clk_i);
			rd(`TMR_ADR_COUNT, b);
			chk(b - a, byte_t'(n + 1 - e));
			pin <= 1'b0;
		end
		wr(`TMR_ADR_OPTION, 8'h20);
		wr(`TMR_ADR_COUNT, 8'h00);
		repeat (16) @(posedge clk_i);
		pulses(2 * n);
		repeat (16) @(posedge clk_i);
		rd(`TMR_ADR_COUNT, a);
		chk(a, byte_t'(n));
		// timer to watchdog: clear, clear count, assign, timer source, clear
		wclr <= 1'b1;
		@(posedge clk_i);
		wclr <= 1'b0;
		wr(`TMR_ADR_COUNT, 8'h00);
		wr(`TMR_ADR_OPTION, 8'h28);
		wr(`TMR_ADR_OPTION, 8'h08);
		wclr <= 1'b1;
		@(posedge clk_i);
		wclr <= 1'b0;
		@(negedge clk_i);
		n = scaled;
		repeat (6) begin
			@(posedge clk_i);
			tick <= 1'b1;
			@(posedge clk_i);
			tick <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		@(negedge clk_i);
		chk(byte_t'(scaled - n), 8'h03);
		end_sim();
	end
endmodule : tb_top
